// ===== logic/sdsb_consts.svh
// named constants of the sync, continuous and buffered data paths
// assumes inclusion by bare name from any design file that needs them
`ifndef SDSB_CONSTS_SVH
`define SDSB_CONSTS_SVH
`define DOP_CONT 2'h0
`define DOP_BUF 2'h1
`define CM_SLEEP 2'h0
`define CM_STBY 2'h1
`define CM_TX 2'h2
`define CM_RX 2'h3
`define IRQA_SYNC 2'h0
`define IRQA_RSSI 2'h1
`define LAST_BIT 3'h7
`define SYNC_MAX 6'h20
`endif

// ===== logic/sdsb_pkg.sv
// types shared by the data path modules
// assumes nothing beyond the constants header
package sdsb_pkg;
  typedef enum logic {ser_idle, ser_shift} ser_state_t;
  typedef enum logic {txg_wait, txg_run} tx_gate_t;
  typedef struct packed {
    logic hold_tog;
    logic pin;
    logic fill;
    logic fill_method;
    logic [1:0] irq_sel;
    logic [31:0] pattern;
    logic [1:0] tol;
    logic [1:0] len;
    logic sync_en;
    logic bsync;
    logic [1:0] cm;
    logic [1:0] dop;
  } bit_cfg_t;
  typedef struct packed {
    logic rx_tog;
    logic take_tog;
    logic done;
  } back_t;
endpackage

// ===== logic/sync_match_if.sv
// carrier between the data path and its sync pattern matcher
// assumes every signal lives in the bit clock domain
`timescale 1ns/1ps
interface sync_match_if;
  logic bit_in;
  logic bit_valid;
  logic enable;
  logic [1:0] length_sel;
  logic [1:0] tolerance;
  logic [31:0] pattern;
  logic match;
  modport matcher (input bit_in, input bit_valid, input enable, input length_sel,
    input tolerance, input pattern, output match);
  modport user (output bit_in, output bit_valid, output enable, output length_sel,
    output tolerance, output pattern, input match);
endinterface

// ===== logic/sync_matcher.sv
// sync pattern matcher with error tolerance
// assumes bit_valid pulses once per received bit, on the bit clock
`timescale 1ns/1ps
`include "sdsb_consts.svh"
module sync_matcher (
  input wire logic clk,
  input wire logic reset,
  sync_match_if.matcher sm
);
  logic [31:0] window_q;
  logic [5:0] seen_q;
  logic checked_q;
  logic [5:0] need;
  logic [31:0] mask;
  logic [31:0] expect_bits;
  logic [31:0] diff;
  logic [5:0] errors;

  // pattern byte 0 sits in bits 31:24, so shorter patterns use the top bytes
  always_comb
  begin
    need = {{1'h0, sm.length_sel} + 3'h1, 3'h0};
    mask = 32'hFFFFFFFF >> (`SYNC_MAX - need);
    expect_bits = sm.pattern >> (`SYNC_MAX - need);
    diff = (window_q ^ expect_bits) & mask;
    errors = 6'h0;
    for (int i = 0; i < 32; i++)
    begin
      errors = errors + {5'h0, diff[i]};
    end
  end

  // no match until a full pattern length has been seen since enabling
  assign sm.match = checked_q && (seen_q >= need) && (errors <= {4'h0, sm.tolerance});

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      window_q <= 32'h0;
      seen_q <= 6'h0;
      checked_q <= 1'h0;
    end
    else if (!sm.enable)
    begin
      seen_q <= 6'h0;
      checked_q <= 1'h0;
    end
    else
    begin
      checked_q <= sm.bit_valid;
      if (sm.bit_valid)
      begin
        window_q <= {window_q[30:0], sm.bit_in};
        if (seen_q != `SYNC_MAX)
          seen_q <= seen_q + 6'h1;
      end
    end
  end

  a_match_filled: assert property (@(posedge clk) disable iff (reset)
    sm.match |-> (seen_q >= need) && (errors <= {4'h0, sm.tolerance}))
    else $error("match before full window or over tolerance");
  a_no_match_off: assert property (@(posedge clk) disable iff (reset)
    !sm.enable |=> !sm.match)
    else $error("match while matcher disabled");
endmodule // sync_matcher

// ===== logic/sync_detect_stream_buffer_modes.sv
// continuous and buffered receive/transmit data paths with sync detection
// assumes clk_bit runs at twice the bit rate; demod_bit, rssi_event, mod_bit,
// the data pin and both event lines belong to clk_bit, the rest to clk_sys
`timescale 1ns/1ps
`include "sdsb_consts.svh"
module sync_detect_stream_buffer_modes #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_bit,
  input wire logic [1:0] data_operation_select,
  input wire logic [1:0] chip_mode,
  input wire logic bit_sync_enable,
  input wire logic sync_match_enable,
  input wire logic [1:0] sync_pattern_length,
  input wire logic [1:0] sync_error_tolerance,
  input wire logic [31:0] sync_pattern_value,
  input wire logic [1:0] irq_a_select,
  input wire logic tx_start_on_full,
  input wire logic fill_trigger_method,
  input wire logic fifo_fill,
  input wire logic fifo_wr_valid,
  input wire logic [7:0] fifo_wr_data,
  input wire logic fifo_rd_req,
  output logic [7:0] fifo_rd_data,
  output logic fifo_not_empty,
  output logic fifo_full,
  output logic overrun_flag,
  input wire logic overrun_clear,
  output logic tx_done,
  input wire logic demod_bit,
  input wire logic rssi_event,
  output logic mod_bit,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe_n,
  output logic irq_a,
  output logic irq_b
);
  localparam int AW = $clog2(FIFO_DEPTH);

  logic hold_tog_q;
  logic [7:0] hold_data_q;
  logic rx_tog_q;
  logic take_tog_q;
  logic done_b_q;
  logic [7:0] rx_byte_q;

  // clk_bit side: every level from clk_sys except hold_data_q, and the data pin,
  // passes three flops and is taken only when the last two agree
  sdsb_pkg::bit_cfg_t cfg_raw;
  sdsb_pkg::bit_cfg_t cfg_s1;
  sdsb_pkg::bit_cfg_t cfg_s2;
  sdsb_pkg::bit_cfg_t cfg_s3;
  sdsb_pkg::bit_cfg_t cfg_b;
  sdsb_pkg::bit_cfg_t cfg_agree;

  assign cfg_raw = '{hold_tog: hold_tog_q, pin: data_pin_in, fill: fifo_fill,
    fill_method: fill_trigger_method, irq_sel: irq_a_select,
    pattern: sync_pattern_value, tol: sync_error_tolerance,
    len: sync_pattern_length, sync_en: sync_match_enable,
    bsync: bit_sync_enable, cm: chip_mode, dop: data_operation_select};
  assign cfg_agree = ~(cfg_s2 ^ cfg_s3);

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
    begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      cfg_s3 <= '0;
      cfg_b <= '0;
    end
    else
    begin
      cfg_s1 <= cfg_raw;
      cfg_s2 <= cfg_s1;
      cfg_s3 <= cfg_s2;
      cfg_b <= (cfg_s3 & cfg_agree) | (cfg_b & ~cfg_agree);
    end
  end

  logic phase_q;
  logic rise_b;
  logic fall_b;
  logic cont_b;
  logic buf_b;
  logic tx_b;
  logic rx_b;
  logic bsync_b;

  // phase_q low means the coming edge raises the bit clock
  assign rise_b = ~phase_q;
  assign fall_b = phase_q;
  assign cont_b = cfg_b.dop == `DOP_CONT;
  assign buf_b = cfg_b.dop == `DOP_BUF;
  assign tx_b = cfg_b.cm == `CM_TX;
  assign rx_b = cfg_b.cm == `CM_RX;
  assign bsync_b = cfg_b.bsync | buf_b;

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
      phase_q <= 1'h0;
    else
      phase_q <= ~phase_q;
  end

  sync_match_if sm ();
  assign sm.bit_in = demod_bit;
  assign sm.bit_valid = rise_b;
  assign sm.enable = rx_b & cfg_b.sync_en & bsync_b & (cont_b | buf_b);
  assign sm.length_sel = cfg_b.len;
  assign sm.tolerance = cfg_b.tol;
  assign sm.pattern = cfg_b.pattern;

  sync_matcher u_match (
    .clk(clk_bit),
    .reset(reset),
    .sm(sm)
  );

  // a match lasts half a bit period (one clk_bit cycle) on the event line
  logic sync_evt_q;
  logic rx_bit_q;

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
    begin
      sync_evt_q <= 1'h0;
      rx_bit_q <= 1'h0;
    end
    else
    begin
      if (sm.match)
        sync_evt_q <= 1'h1;
      else if (rise_b)
        sync_evt_q <= 1'h0;
      if (rise_b)
        rx_bit_q <= demod_bit;
    end
  end

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
    begin
      data_pin_out <= 1'h0;
      data_pin_oe_n <= 1'h1;
    end
    else
    begin
      data_pin_oe_n <= ~(cont_b & rx_b);
      if (cont_b & rx_b & ~cfg_b.bsync)
        data_pin_out <= demod_bit;
      else if (cont_b & rx_b & fall_b)
        data_pin_out <= rx_bit_q;
    end
  end

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
    begin
      irq_a <= 1'h0;
      irq_b <= 1'h0;
    end
    else
    begin
      irq_b <= cont_b & (tx_b | (rx_b & cfg_b.bsync)) & ~phase_q;
      if (cont_b & rx_b)
      begin
        case (cfg_b.irq_sel)
          `IRQA_SYNC: irq_a <= sync_evt_q;
          `IRQA_RSSI: irq_a <= rssi_event;
          default: irq_a <= 1'h0;
        endcase
      end
      else
        irq_a <= 1'h0;
    end
  end

  // transmit path: pin sampling in continuous mode, serializer in buffered
  sdsb_pkg::ser_state_t ser_state_q;
  logic [7:0] ser_q;
  logic [2:0] ser_cnt_q;
  logic hold_seen_q;
  logic hold_avail_b;
  logic byte_end_b;

  assign hold_avail_b = cfg_b.hold_tog != hold_seen_q;
  assign byte_end_b = (ser_state_q == sdsb_pkg::ser_idle) || (ser_cnt_q == `LAST_BIT);

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
    begin
      ser_state_q <= sdsb_pkg::ser_idle;
      ser_q <= 8'h0;
      ser_cnt_q <= 3'h0;
      hold_seen_q <= 1'h0;
      take_tog_q <= 1'h0;
      done_b_q <= 1'h0;
      mod_bit <= 1'h0;
    end
    else if (cont_b & tx_b)
    begin
      ser_state_q <= sdsb_pkg::ser_idle;
      hold_seen_q <= cfg_b.hold_tog;
      done_b_q <= 1'h0;
      if (rise_b)
        mod_bit <= cfg_b.pin;
    end
    else if (!(buf_b & tx_b))
    begin
      // unsent bits and any staged byte are dropped at once
      ser_state_q <= sdsb_pkg::ser_idle;
      ser_cnt_q <= 3'h0;
      hold_seen_q <= cfg_b.hold_tog;
      done_b_q <= 1'h0;
      mod_bit <= 1'h0;
    end
    else if (fall_b)
    begin
      if (byte_end_b & hold_avail_b)
      begin
        mod_bit <= hold_data_q[7];
        ser_q <= {hold_data_q[6:0], 1'h0};
        ser_cnt_q <= 3'h0;
        ser_state_q <= sdsb_pkg::ser_shift;
        hold_seen_q <= cfg_b.hold_tog;
        take_tog_q <= ~take_tog_q;
        done_b_q <= 1'h0;
      end
      else if (byte_end_b)
      begin
        if (ser_state_q == sdsb_pkg::ser_shift)
          done_b_q <= 1'h1;
        ser_state_q <= sdsb_pkg::ser_idle;
      end
      else
      begin
        mod_bit <= ser_q[7];
        ser_q <= {ser_q[6:0], 1'h0};
        ser_cnt_q <= ser_cnt_q + 3'h1;
      end
    end
  end

  // receive path of buffered mode
  logic fill_act_q;
  logic [7:0] rx_sr_q;
  logic [2:0] rx_cnt_q;

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
      fill_act_q <= 1'h0;
    else if (!(buf_b & rx_b))
      fill_act_q <= 1'h0;
    else if (cfg_b.fill_method)
      fill_act_q <= cfg_b.fill;
    else if (sm.match)
      fill_act_q <= 1'h1;
  end

  always_ff @(posedge clk_bit or posedge reset)
  begin
    if (reset)
    begin
      rx_sr_q <= 8'h0;
      rx_cnt_q <= 3'h0;
      rx_byte_q <= 8'h0;
      rx_tog_q <= 1'h0;
    end
    // only the match that opens the fill aligns bytes; later payload matches must not
    else if (!fill_act_q)
      rx_cnt_q <= 3'h0;
    else if (rise_b)
    begin
      rx_sr_q <= {rx_sr_q[6:0], demod_bit};
      rx_cnt_q <= rx_cnt_q + 3'h1;
      if (rx_cnt_q == `LAST_BIT)
      begin
        rx_byte_q <= {rx_sr_q[6:0], demod_bit};
        rx_tog_q <= ~rx_tog_q;
      end
    end
  end

  // clk_sys side: toggles and done level come back through three flops;
  // rx_byte_q is stable for a whole byte time when its toggle is seen
  sdsb_pkg::back_t back_raw;
  sdsb_pkg::back_t bk_s1;
  sdsb_pkg::back_t bk_s2;
  sdsb_pkg::back_t bk_s3;
  sdsb_pkg::back_t back_s;
  sdsb_pkg::back_t back_prev_q;
  sdsb_pkg::back_t back_agree;

  assign back_raw = '{rx_tog: rx_tog_q, take_tog: take_tog_q, done: done_b_q};
  assign back_agree = ~(bk_s2 ^ bk_s3);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bk_s1 <= '0;
      bk_s2 <= '0;
      bk_s3 <= '0;
      back_s <= '0;
      back_prev_q <= '0;
    end
    else
    begin
      bk_s1 <= back_raw;
      bk_s2 <= bk_s1;
      bk_s3 <= bk_s2;
      back_s <= (bk_s3 & back_agree) | (back_s & ~back_agree);
      back_prev_q <= back_s;
    end
  end

  logic cont_s;
  logic buf_s;
  logic tx_s;
  logic rx_s;
  logic [1:0] cm_prev_q;
  logic clear_fifo;
  logic [7:0] mem_q [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic full_now;
  logic empty_now;
  logic push;
  logic do_push;
  logic [7:0] push_data;
  logic host_pop;
  logic hold_load;
  logic do_pop;
  logic hold_full_q;
  sdsb_pkg::tx_gate_t tx_state_q;

  assign cont_s = data_operation_select == `DOP_CONT;
  assign buf_s = data_operation_select == `DOP_BUF;
  assign tx_s = chip_mode == `CM_TX;
  assign rx_s = chip_mode == `CM_RX;
  // entering tx, rx or sleep empties the FIFO; standby keeps it readable
  assign clear_fifo = ((chip_mode != cm_prev_q) && (chip_mode != `CM_STBY))
    || overrun_clear;
  assign full_now = count_q == (AW+1)'(FIFO_DEPTH);
  assign empty_now = count_q == '0;
  // in continuous and packet selections the FIFO is only cleared, never pushed or popped
  assign push = buf_s & (rx_s ? (back_s.rx_tog != back_prev_q.rx_tog) : fifo_wr_valid);
  assign push_data = rx_s ? rx_byte_q : fifo_wr_data;
  assign do_push = push & ~full_now & ~clear_fifo;
  assign host_pop = fifo_rd_req & buf_s & ~tx_s & ~empty_now;
  assign hold_load = (tx_state_q == sdsb_pkg::txg_run) & ~hold_full_q & ~empty_now
    & buf_s & tx_s;
  assign do_pop = (host_pop | hold_load) & ~clear_fifo;
  assign fifo_not_empty = ~empty_now;
  assign fifo_full = full_now;

  always_ff @(posedge clk_sys)
  begin
    if (do_push)
      mem_q[wr_ptr_q] <= push_data;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cm_prev_q <= `CM_SLEEP;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      fifo_rd_data <= 8'h0;
    end
    else
    begin
      cm_prev_q <= chip_mode;
      if (clear_fifo)
      begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q <= '0;
      end
      else
      begin
        if (do_push)
          wr_ptr_q <= wr_ptr_q + AW'(1);
        if (do_pop)
          rd_ptr_q <= rd_ptr_q + AW'(1);
        count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
      if (host_pop & ~clear_fifo)
        fifo_rd_data <= mem_q[rd_ptr_q];
    end
  end

  // a byte arriving while full is lost; the set beats a same-cycle clear
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      overrun_flag <= 1'h0;
    else if (push & full_now)
      overrun_flag <= 1'h1;
    else if (overrun_clear)
      overrun_flag <= 1'h0;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      tx_state_q <= sdsb_pkg::txg_wait;
    else if (!(buf_s & tx_s))
      tx_state_q <= sdsb_pkg::txg_wait;
    else if (tx_start_on_full ? full_now : ~empty_now)
      tx_state_q <= sdsb_pkg::txg_run;
  end

  // one staged byte waits for the serializer; its toggle hands it over
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      hold_full_q <= 1'h0;
      hold_data_q <= 8'h0;
      hold_tog_q <= 1'h0;
      tx_done <= 1'h0;
    end
    else
    begin
      tx_done <= back_s.done & buf_s & tx_s;
      if (!(buf_s & tx_s))
        hold_full_q <= 1'h0;
      else if (hold_load & ~clear_fifo)
      begin
        hold_full_q <= 1'h1;
        hold_data_q <= mem_q[rd_ptr_q];
        hold_tog_q <= ~hold_tog_q;
      end
      else if (back_s.take_tog != back_prev_q.take_tog)
        hold_full_q <= 1'h0;
    end
  end

  a_overrun_set: assert property (@(posedge clk_sys) disable iff (reset)
    (push && full_now) |=> overrun_flag && fifo_full == (!$past(do_pop) && !$past(clear_fifo)))
    else $error("full FIFO push did not flag overrun");
  a_clear_empty: assert property (@(posedge clk_sys) disable iff (reset)
    overrun_clear |=> !fifo_not_empty)
    else $error("overrun clear left FIFO non-empty");
  a_cont_no_fifo: assert property (@(posedge clk_sys) disable iff (reset)
    (cont_s && empty_now) |=> empty_now)
    else $error("FIFO filled in continuous mode");
  a_start_waits: assert property (@(posedge clk_sys) disable iff (reset)
    (tx_state_q == sdsb_pkg::txg_wait) |=> !hold_full_q)
    else $error("byte sent before start condition");
  a_bit_clock_out_toggle: assert property (@(posedge clk_bit) disable iff (reset)
    (cont_b && tx_b) [*2] |=> (irq_b != $past(irq_b)))
    else $error("bit clock not toggling in continuous tx");
  a_raw_pass: assert property (@(posedge clk_bit) disable iff (reset)
    (cont_b && rx_b && !cfg_b.bsync) |=> (data_pin_out == $past(demod_bit)) && !irq_b)
    else $error("raw rx data not passed or clock present");
  a_stby_quiet: assert property (@(posedge clk_bit) disable iff (reset)
    (cont_b && cfg_b.cm == `CM_STBY) |=> !irq_a && !irq_b)
    else $error("event lines active in continuous standby");
  a_tx_abort: assert property (@(posedge clk_bit) disable iff (reset)
    !(buf_b && tx_b) |=> (ser_state_q == sdsb_pkg::ser_idle) && !done_b_q)
    else $error("serializer kept running after tx left");
endmodule // sync_detect_stream_buffer_modes

// ===== testbench/host_far_side.sv
// far side model: demodulator bit feed and the host driving the data pin
// assumes clk_bit is the link clock and irq_b the bit clock in continuous tx
`timescale 1ns/1ps
module host_far_side (
  input wire logic clk_bit,
  input wire logic irq_b,
  output logic demod_bit,
  output logic data_pin_in
);
  logic [7:0] tx_pat;
  initial
  begin
    demod_bit = 1'b0;
    data_pin_in = 1'b0;
    tx_pat = 8'hC6;
  end
  // each bit holds a full bit period so the phase-low sample always sees it
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_bit);
      #1 demod_bit = b[i];
      @(posedge clk_bit);
    end
  endtask
  // change data as the bit clock falls, well away from its sampling rise
  always @(negedge irq_b)
  begin
    data_pin_in <= tx_pat[7];
    tx_pat <= {tx_pat[6:0], tx_pat[7]};
  end
endmodule // host_far_side

// ===== testbench/sync_detect_stream_buffer_modes_test.sv
// self-checking bench of the sync, continuous and buffered data paths
// assumes the design files and host_far_side are compiled first
`timescale 1ns/1ps
module sync_detect_stream_buffer_modes_test;
  localparam int DEPTH = 16;
  logic clk_sys, clk_bit, reset;
  logic [1:0] dop, cm, len, tol, irq_sel;
  logic bsync, sync_en, start_full, method, fill, wr_v, rd_req, ovr_clr, rssi;
  logic [7:0] wr_d, rd_data, b;
  logic [31:0] pattern;
  logic not_empty, full, ovr, done, mod_bit, pin_in, pin_out, oe_n, irq_a, irq_b, demod;
  logic rd_q, chk_raw, capture, prev_demod, prev_rssi, found;
  logic [15:0] win;
  logic [7:0] exp_q[$];
  logic [7:0] wbytes[DEPTH];
  logic bits_q[$];
  int failures, n_compared, cycles, t, edges, ones;
  integer seed;

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_bit = 1'b0;
    #3;
    forever #7.5 clk_bit = ~clk_bit;
  end

  sync_detect_stream_buffer_modes #(.FIFO_DEPTH(DEPTH)) uut (.clk_sys(clk_sys),
    .reset(reset), .clk_bit(clk_bit), .data_operation_select(dop), .chip_mode(cm),
    .bit_sync_enable(bsync), .sync_match_enable(sync_en), .sync_pattern_length(len),
    .sync_error_tolerance(tol), .sync_pattern_value(pattern), .irq_a_select(irq_sel),
    .tx_start_on_full(start_full), .fill_trigger_method(method), .fifo_fill(fill),
    .fifo_wr_valid(wr_v), .fifo_wr_data(wr_d), .fifo_rd_req(rd_req),
    .fifo_rd_data(rd_data), .fifo_not_empty(not_empty), .fifo_full(full),
    .overrun_flag(ovr), .overrun_clear(ovr_clr), .tx_done(done), .demod_bit(demod),
    .rssi_event(rssi), .mod_bit(mod_bit), .data_pin_in(pin_in), .data_pin_out(pin_out),
    .data_pin_oe_n(oe_n), .irq_a(irq_a), .irq_b(irq_b));
  host_far_side far (.clk_bit(clk_bit), .irq_b(irq_b), .demod_bit(demod),
    .data_pin_in(pin_in));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_bit(input int n);
    repeat (n) @(posedge clk_bit);
    tick();
  endtask
  // a full pattern period of mod_bit lies in the last 16 samples, whatever its phase
  task automatic count_clock();
    edges = 0;
    ones = 0;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk_bit);
      #1 if (irq_b === 1'b1) edges++;
      if (i >= 4 && mod_bit === 1'b1) ones++;
    end
  endtask
  task automatic write_byte(input logic [7:0] v);
    tick();
    wr_v = 1'b1;
    wr_d = v;
    tick();
    wr_v = 1'b0;
  endtask
  task automatic read_byte(input logic [7:0] v);
    tick();
    rd_req = 1'b1;
    exp_q.push_back(v);
    tick();
    rd_req = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // read data stands from the cycle after the request until the next read
  always @(posedge clk_sys)
  begin
    if (rd_q && exp_q.size() > 0)
      check(rd_data, exp_q.pop_front());
    rd_q <= rd_req;
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end
  always @(posedge clk_bit)
  begin
    if (chk_raw)
    begin
      check({oe_n, irq_b, pin_out}, {2'b00, prev_demod});
      check(irq_a, irq_sel == 2'h1 ? prev_rssi : 1'b0);
    end
    if (capture)
      bits_q.push_back(mod_bit);
    prev_demod <= demod;
    prev_rssi <= rssi;
    rssi <= $random(seed);
  end

  initial
  begin
    seed = 32'heef25444;
    {dop, cm, len, tol, irq_sel} = '0;
    {bsync, sync_en, start_full, method, fill, wr_v, rd_req, ovr_clr} = '0;
    {chk_raw, capture} = '0;
    wr_d = 8'h00;
    pattern = 32'hF0000000;
    reset = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    // buffered standby: fill to full, read back, overrun, clear
    dop = 2'h1;
    cm = 2'h1;
    wait_bit(8);
    for (int i = 0; i < DEPTH; i++)
    begin
      wbytes[i] = $random(seed);
      write_byte(wbytes[i]);
    end
    tick();
    check(full, 1'b1);
    read_byte(wbytes[0]);
    write_byte(8'h3C);
    tick();
    check({full, ovr}, 2'b10);
    write_byte(8'h77);
    tick();
    check(ovr, 1'b1);
    ovr_clr = 1'b1;
    tick();
    ovr_clr = 1'b0;
    tick();
    check({ovr, not_empty, full}, 3'b000);
    // continuous rx, bit sync off: raw bits and rssi, then line A silent
    dop = 2'h0;
    cm = 2'h3;
    irq_sel = 2'h1;
    wait_bit(10);
    chk_raw = 1'b1;
    far.send_byte($random(seed));
    chk_raw = 1'b0;
    irq_sel = 2'h2;
    wait_bit(10);
    chk_raw = 1'b1;
    far.send_byte($random(seed));
    chk_raw = 1'b0;
    // continuous rx, bit sync on: recovered clock on line B, sync event on line A
    bsync = 1'b1;
    sync_en = 1'b1;
    irq_sel = 2'h0;
    wait_bit(10);
    count_clock();
    check(edges, 10);
    check({pin_out, oe_n}, {demod, 1'b0});
    found = 1'b0;
    far.send_byte(8'hF0);
    repeat (8)
    begin
      @(posedge clk_bit);
      #1 if (irq_a === 1'b1) found = 1'b1;
    end
    check({found, pin_out}, 2'b10);
    // continuous tx: bit clock toggles each link cycle, pin bits reach the modulator
    cm = 2'h2;
    wait_bit(10);
    count_clock();
    check(edges, 10);
    check(ones, 8);
    check(irq_a, 1'b0);
    cm = 2'h1;
    wait_bit(10);
    check({irq_a, irq_b}, 2'b00);
    // buffered rx: one errored sync byte, only the following bytes stored
    dop = 2'h1;
    cm = 2'h3;
    sync_en = 1'b1;
    tol = 2'h1;
    wait_bit(10);
    foreach (wbytes[i])
      if (i < 5) far.send_byte(i < 2 ? 8'h00 : i == 2 ? 8'hF1 : i == 3 ? 8'h5A : 8'hC3);
    wait_bit(10);
    read_byte(8'h5A);
    read_byte(8'hC3);
    // buffered tx: one byte out MSB first, done eight bit periods later
    cm = 2'h2;
    wait_bit(10);
    capture = 1'b1;
    write_byte(8'hA5);
    for (t = 0; t < 80 && done !== 1'b1; t++)
      tick();
    capture = 1'b0;
    check(t >= 20 && t < 60, 1'b1);
    check(not_empty, 1'b0);
    found = 1'b0;
    win = '0;
    foreach (bits_q[i])
    begin
      win = {win[14:0], bits_q[i]};
      if (win === 16'hCC33) found = 1'b1;
    end
    check(found, 1'b1);
    // leave tx in mid-byte: sending stops at once
    cm = 2'h1;
    wait_bit(10);
    cm = 2'h2;
    wait_bit(10);
    write_byte(8'hFF);
    write_byte(8'hFF);
    wait_bit(20);
    check(mod_bit, 1'b1);
    cm = 2'h1;
    wait_bit(12);
    repeat (16)
    begin
      @(posedge clk_bit);
      check(mod_bit, 1'b0);
    end
    report_and_stop();
  end
endmodule // sync_detect_stream_buffer_modes_test
